// ==== acpi_power_pkg.sv ====
// Purpose: shared constants and types for the power state sequencer
// Assumes: 100 MHz suspend-well clock
// Notes:   times in microseconds, counts derived from the clock rate
package acpi_power_pkg;

    localparam int CLK_MHZ          = 100;
    localparam int DEBOUNCE_US      = 10;
    localparam int DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
    localparam int PENDING_US       = 20;
    localparam int PENDING_CYC      = PENDING_US * CLK_MHZ;
    localparam int SYNC_STAGES      = 2;
    localparam int NUM_INPUTS       = 7;
    localparam int CNT_W            = 16;

    // input positions inside the conditioned vector
    localparam int IN_RESET_BTN     = 0;
    localparam int IN_BATTERY_LOW   = 1;
    localparam int IN_WAKE          = 2;
    localparam int IN_SLEEP_BTN     = 3;
    localparam int IN_LID           = 4;
    localparam int IN_THERM_ALARM   = 5;
    localparam int IN_POWER_BTN     = 6;

    // reset value of every conditioned active-low input: released
    localparam logic [NUM_INPUTS-1:0] IN_IDLE = 7'h7F;

    typedef enum logic [2:0] {
        ST_S0 = 3'b000,
        ST_S1 = 3'b001,
        ST_S3 = 3'b011,
        ST_S4 = 3'b100,
        ST_S5 = 3'b101
    } power_state_t;

    typedef struct packed {
        logic suspend_pending_n;
        logic suspend_ram_n;
        logic soft_off_n;
        logic standby_rail_en;
        logic low_power_hint;
        logic throttle;
    } power_out_t;

    typedef struct packed {
        logic sleep_s1;
        logic sleep_s3;
        logic sleep_s4;
        logic soft_off;
        logic wake_support;
    } os_request_t;

endpackage

// ==== input_conditioner.sv ====
// Purpose: two-stage synchroniser and debounce for one active-low pin
// Assumes: pin is asynchronous to sys_clk
// Notes:   output changes only after the pin holds steady for DEBOUNCE
`timescale 1ns/1ns
module input_conditioner #(
    parameter int DEBOUNCE = acpi_power_pkg::DEBOUNCE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic pin_n,
    output logic      clean_n
);
    logic             meta_q;
    logic             sync_q;
    logic [15:0]      cnt_q;
    logic [15:0]      cnt_d;
    logic             clean_d;

    // ----------------------------------------------------------------
    // debounce
    // ----------------------------------------------------------------
    always_comb begin
        cnt_d   = cnt_q;
        clean_d = clean_n;
        if (sync_q == clean_n) begin
            cnt_d = 16'h0000;
        end else if (cnt_q >= 16'(DEBOUNCE - 1)) begin
            cnt_d   = 16'h0000;
            clean_d = sync_q;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q  <= 1'b1;
            sync_q  <= 1'b1;
            cnt_q   <= 16'h0000;
            clean_n <= 1'b1;
        end else begin
            meta_q  <= pin_n;
            sync_q  <= meta_q;
            cnt_q   <= cnt_d;
            clean_n <= clean_d;
        end
    end
endmodule

// ==== acpi_power_state_control.sv ====
// Purpose: system power state sequencer, S0 to S5, with suspend outputs
// Assumes: runs on the suspend-well clock, standby power always present
// Notes:   os requests come from on-module logic on the same clock
//
// Overview of operation
// - S0: all rails on, fully operational
// - S1: rails stay on, context kept
// - S3: only memory and wake logic powered
// - S5 restarts only on button or wake
// - S5 standby rails kept only if wake needed
// - reset button low holds module in reset
// - battery low input registered as event
// - wake input low is a wake event
// - suspend pending low announces coming sleep
// - suspend-to-RAM asserted in S3, S4, S5
// - soft-off asserted only in S4, S5
// - sleep button falling edge toggles sleep
// - lid switch sleeps or wakes the system
// - thermal trip forces immediate S5
// - thermal alarm low may start throttling
// - a wake event returns S1, S3, S4 to S0; S5 only on the power button, or with wake support
`timescale 1ns/1ns
module acpi_power_state_control #(
    parameter int DEBOUNCE = acpi_power_pkg::DEBOUNCE_CYC,
    parameter int PENDING  = acpi_power_pkg::PENDING_CYC
) (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic                         reset_button_n,
    input  wire logic                         battery_low_n,
    input  wire logic                         wake_n,
    input  wire logic                         sleep_button_n,
    input  wire logic                         lid_switch_n,
    input  wire logic                         thermal_alarm_n,
    input  wire logic                         power_button_n,
    input  wire logic                         thermal_trip_n,
    input  wire acpi_power_pkg::os_request_t  os_req,
    input  wire logic                         lid_closed_level,
    input  wire logic                         battery_event_clr,
    output logic                              suspend_pending_n,
    output logic                              suspend_ram_n,
    output logic                              soft_off_n,
    output logic                              standby_rail_en,
    output logic                              low_power_hint,
    output logic                              throttle,
    output logic                              battery_event,
    output logic                              module_reset_n,
    output acpi_power_pkg::power_state_t      power_state
);
    logic [acpi_power_pkg::NUM_INPUTS-1:0]  raw_n;
    logic [acpi_power_pkg::NUM_INPUTS-1:0]  clean_n;
    logic [acpi_power_pkg::NUM_INPUTS-1:0]  prev_q;
    logic [acpi_power_pkg::NUM_INPUTS-1:0]  fall;
    logic                                   trip_meta_q;
    logic                                   trip_sync_q;

    acpi_power_pkg::power_state_t           state_q;
    acpi_power_pkg::power_state_t           state_d;
    acpi_power_pkg::power_state_t           target_q;
    acpi_power_pkg::power_state_t           target_d;
    logic                                   pending_q;
    logic                                   pending_d;
    logic [acpi_power_pkg::CNT_W-1:0]       pend_cnt_q;
    logic [acpi_power_pkg::CNT_W-1:0]       pend_cnt_d;
    logic                                   wake_sup_q;
    logic                                   wake_sup_d;
    logic                                   bat_q;
    logic                                   bat_d;
    acpi_power_pkg::power_out_t             out_q;
    acpi_power_pkg::power_out_t             out_d;

    logic                                   asleep;
    logic                                   wake_ev;
    logic                                   sleep_ev;
    logic                                   lid_closed;
    logic                                   lid_change;

    // ----------------------------------------------------------------
    // input conditioning
    // ----------------------------------------------------------------
    assign raw_n[acpi_power_pkg::IN_RESET_BTN]   = reset_button_n;
    assign raw_n[acpi_power_pkg::IN_BATTERY_LOW] = battery_low_n;
    assign raw_n[acpi_power_pkg::IN_WAKE]        = wake_n;
    assign raw_n[acpi_power_pkg::IN_SLEEP_BTN]   = sleep_button_n;
    assign raw_n[acpi_power_pkg::IN_LID]         = lid_switch_n;
    assign raw_n[acpi_power_pkg::IN_THERM_ALARM] = thermal_alarm_n;
    assign raw_n[acpi_power_pkg::IN_POWER_BTN]   = power_button_n;

    genvar gi;
    generate
        for (gi = 0; gi < acpi_power_pkg::NUM_INPUTS; gi++) begin : g_in
            input_conditioner #(
                .DEBOUNCE (DEBOUNCE)
            ) u_cond (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .pin_n   (raw_n[gi]),
                .clean_n (clean_n[gi])
            );
        end
    endgenerate

    assign fall = prev_q & ~clean_n;

    // trip is not debounced: a hot die cannot wait for a filter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_meta_q <= 1'b1;
            trip_sync_q <= 1'b1;
            prev_q      <= acpi_power_pkg::IN_IDLE;
        end else begin
            trip_meta_q <= thermal_trip_n;
            trip_sync_q <= trip_meta_q;
            prev_q      <= clean_n;
        end
    end

    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------
    assign asleep     = (state_q != acpi_power_pkg::ST_S0);
    // polarity of a closed lid is strap-selected, since it is board dependent
    assign lid_closed = (clean_n[acpi_power_pkg::IN_LID] == lid_closed_level);
    assign lid_change = (prev_q[acpi_power_pkg::IN_LID] != clean_n[acpi_power_pkg::IN_LID]);

    always_comb begin
        wake_ev  = 1'b0;
        sleep_ev = 1'b0;
        if (!clean_n[acpi_power_pkg::IN_WAKE]) begin
            wake_ev = 1'b1;
        end
        if (fall[acpi_power_pkg::IN_POWER_BTN]) begin
            wake_ev = 1'b1;
        end
        if (fall[acpi_power_pkg::IN_SLEEP_BTN]) begin
            if (asleep) begin
                wake_ev = 1'b1;
            end else begin
                sleep_ev = 1'b1;
            end
        end
        if (lid_change) begin
            if (lid_closed) begin
                sleep_ev = 1'b1;
            end else begin
                wake_ev = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // battery low event
    // ----------------------------------------------------------------
    always_comb begin
        bat_d = bat_q;
        if (battery_event_clr) begin
            bat_d = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (fall[acpi_power_pkg::IN_BATTERY_LOW]) begin
            bat_d = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        target_d   = target_q;
        pending_d  = pending_q;
        pend_cnt_d = pend_cnt_q;
        wake_sup_d = wake_sup_q;
        if (os_req.soft_off || os_req.sleep_s3 || os_req.sleep_s4) begin
            wake_sup_d = os_req.wake_support;
        end
        if (!trip_sync_q) begin
            state_d    = acpi_power_pkg::ST_S5;
            pending_d  = 1'b0;
            pend_cnt_d = '0;
        end else if (pending_q) begin
            // announce first, then drop rails once the hold has run
            if (pend_cnt_q >= acpi_power_pkg::CNT_W'(PENDING - 1)) begin
                state_d    = target_q;
                pending_d  = 1'b0;
                pend_cnt_d = '0;
            end else begin
                pend_cnt_d = pend_cnt_q + 1'b1;
            end
        end else begin
            case (state_q)
                acpi_power_pkg::ST_S0: begin
                    if (os_req.soft_off) begin
                        target_d  = acpi_power_pkg::ST_S5;
                        pending_d = 1'b1;
                    end else if (os_req.sleep_s4) begin
                        target_d  = acpi_power_pkg::ST_S4;
                        pending_d = 1'b1;
                    end else if (os_req.sleep_s3 || sleep_ev) begin
                        target_d  = acpi_power_pkg::ST_S3;
                        pending_d = 1'b1;
                    end else if (os_req.sleep_s1) begin
                        target_d  = acpi_power_pkg::ST_S1;
                        pending_d = 1'b1;
                    end
                end
                acpi_power_pkg::ST_S1,
                acpi_power_pkg::ST_S3,
                acpi_power_pkg::ST_S4: begin
                    if (wake_ev) begin
                        state_d = acpi_power_pkg::ST_S0;
                    end
                end
                acpi_power_pkg::ST_S5: begin
                    // only the button, or a wake when wake support is on
                    if (fall[acpi_power_pkg::IN_POWER_BTN] ||
                        (wake_ev && wake_sup_q)) begin
                        state_d = acpi_power_pkg::ST_S0;
                    end
                end
                default: begin
                    state_d = acpi_power_pkg::ST_S5;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output decode
    // ----------------------------------------------------------------
    always_comb begin
        out_d                   = '0;
        out_d.suspend_pending_n = !pending_d;
        out_d.suspend_ram_n     = 1'b1;
        out_d.soft_off_n        = 1'b1;
        out_d.standby_rail_en   = 1'b1;
        out_d.throttle          = !clean_n[acpi_power_pkg::IN_THERM_ALARM];
        case (state_d)
            acpi_power_pkg::ST_S1: begin
                out_d.low_power_hint = 1'b1;
            end
            acpi_power_pkg::ST_S3: begin
                out_d.suspend_ram_n = 1'b0;
            end
            acpi_power_pkg::ST_S4,
            acpi_power_pkg::ST_S5: begin
                out_d.suspend_ram_n   = 1'b0;
                out_d.soft_off_n      = 1'b0;
                out_d.standby_rail_en = wake_sup_d;
            end
            default: begin
                out_d.low_power_hint = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= acpi_power_pkg::ST_S5;
            target_q   <= acpi_power_pkg::ST_S5;
            pending_q  <= 1'b0;
            pend_cnt_q <= '0;
            wake_sup_q <= 1'b1;
            bat_q      <= 1'b0;
            out_q      <= '{suspend_pending_n: 1'b1, suspend_ram_n: 1'b0, soft_off_n: 1'b0,
                            standby_rail_en: 1'b1, low_power_hint: 1'b0, throttle: 1'b0};
        end else begin
            state_q    <= state_d;
            target_q   <= target_d;
            pending_q  <= pending_d;
            pend_cnt_q <= pend_cnt_d;
            wake_sup_q <= wake_sup_d;
            bat_q      <= bat_d;
            out_q      <= out_d;
        end
    end

    // the supply request is the carrier's inverter on suspend_ram_n
    assign suspend_pending_n = out_q.suspend_pending_n;
    assign suspend_ram_n     = out_q.suspend_ram_n;
    assign soft_off_n        = out_q.soft_off_n;
    assign standby_rail_en   = out_q.standby_rail_en;
    assign low_power_hint    = out_q.low_power_hint;
    assign throttle          = out_q.throttle;
    assign battery_event     = bat_q;
    assign power_state       = state_q;
    // held low while the debounced reset button is pressed
    assign module_reset_n    = clean_n[acpi_power_pkg::IN_RESET_BTN];
endmodule

// ==== power_checker_properties.sv ====
// Purpose: port-level checks on the power state sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bounds follow the debounce and pending counts of the design
`timescale 1ns/1ns
module power_checker #(
    parameter int DEBOUNCE = acpi_power_pkg::DEBOUNCE_CYC,
    parameter int PENDING  = acpi_power_pkg::PENDING_CYC
) (
    input wire logic                          sys_clk,
    input wire logic                          rst_n,
    input wire logic                          reset_button_n,
    input wire logic                          wake_n,
    input wire logic                          thermal_alarm_n,
    input wire logic                          thermal_trip_n,
    input wire acpi_power_pkg::os_request_t   os_req,
    input wire logic                          battery_event_clr,
    input wire logic                          suspend_pending_n,
    input wire logic                          suspend_ram_n,
    input wire logic                          soft_off_n,
    input wire logic                          standby_rail_en,
    input wire logic                          low_power_hint,
    input wire logic                          throttle,
    input wire logic                          battery_event,
    input wire logic                          module_reset_n,
    input wire acpi_power_pkg::power_state_t  power_state
);
    wire s0 = power_state == acpi_power_pkg::ST_S0;
    wire s1 = power_state == acpi_power_pkg::ST_S1;
    wire s3 = power_state == acpi_power_pkg::ST_S3;
    wire s4 = power_state == acpi_power_pkg::ST_S4;
    wire s5 = power_state == acpi_power_pkg::ST_S5;
    wire req = os_req.sleep_s1 | os_req.sleep_s3 | os_req.sleep_s4 | os_req.soft_off;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // consecutive-cycle counters, saturating; a range delay cannot follow a long debounce
    logic [15:0] alarm_low_q;
    logic [15:0] reset_low_q;
    logic [15:0] wake_low_q;
    logic [15:0] pend_low_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_low_q <= 16'h0000;
            reset_low_q <= 16'h0000;
            wake_low_q  <= 16'h0000;
            pend_low_q  <= 16'h0000;
        end else begin
            alarm_low_q <= thermal_alarm_n ? 16'h0000 : alarm_low_q + 16'(~&alarm_low_q);
            reset_low_q <= reset_button_n ? 16'h0000 : reset_low_q + 16'(~&reset_low_q);
            wake_low_q  <= (wake_n || !s3) ? 16'h0000 : wake_low_q + 16'(~&wake_low_q);
            pend_low_q  <= suspend_pending_n ? 16'h0000 : pend_low_q + 16'(~&pend_low_q);
        end
    end
    // ----------------------------------------
    // state and output relations
    // ----------------------------------------
    sequence s_sleep_entry;
        s0 ##1 (s1 || s3);
    endsequence
    a_ram_in_sleep: assert property (suspend_ram_n == !(s3 || s4 || s5))
        else $error("suspend-to-RAM output does not match state");
    a_soft_in_off: assert property (soft_off_n == !(s4 || s5))
        else $error("soft-off output does not match state");
    a_s0_all_on: assert property (s0 |-> suspend_ram_n && soft_off_n && standby_rail_en && !low_power_hint)
        else $error("rails not all on in full-on state");
    a_s1_rails_kept: assert property (s1 |-> suspend_ram_n && standby_rail_en && low_power_hint)
        else $error("standby state dropped a rail");
    a_s3_memory_kept: assert property (s3 |-> standby_rail_en)
        else $error("standby rail lost in suspend-to-RAM");
    a_sleep_announced: assert property (s_sleep_entry |-> $past(suspend_pending_n) == 1'b0)
        else $error("sleep entered without pending notice");
    a_req_announce: assert property (req && s0 && suspend_pending_n |=> !suspend_pending_n)
        else $error("sleep request not announced");
    a_pending_bound: assert property (pend_low_q <= 16'(PENDING))
        else $error("pending notice held too long");
    a_trip_to_off: assert property (!thermal_trip_n [*5] |-> s5)
        else $error("thermal trip did not force soft-off");
    a_wake_to_s0: assert property (wake_low_q <= 16'(DEBOUNCE + 4))
        else $error("wake request did not return to full-on");
    a_battery_sticky: assert property (battery_event && !battery_event_clr |=> battery_event)
        else $error("battery event dropped without clear");
    a_alarm_throttle: assert property (alarm_low_q >= 16'(DEBOUNCE + 3) |-> throttle)
        else $error("thermal alarm did not throttle");
    a_reset_hold: assert property (reset_low_q >= 16'(DEBOUNCE + 3) |-> !module_reset_n)
        else $error("reset button did not hold module in reset");
endmodule

bind acpi_power_state_control power_checker #(.DEBOUNCE(DEBOUNCE), .PENDING(PENDING)) u_chk (
    .sys_clk, .rst_n, .reset_button_n, .wake_n, .thermal_alarm_n, .thermal_trip_n, .os_req,
    .battery_event_clr, .suspend_pending_n, .suspend_ram_n, .soft_off_n, .standby_rail_en,
    .low_power_hint, .throttle, .battery_event, .module_reset_n, .power_state
);

// ==== carrier_model.sv ====
// Purpose: carrier board side: open-drain pins, supply and rail switching
// Assumes: pins idle high through pull-ups
// Notes:   a set bit of pull pulls that pin low
`timescale 1ns/1ns
module carrier_model (
    input  wire logic       suspend_ram_n,
    input  wire logic [7:0] pull,
    output logic      [7:0] line_n,
    output logic            supply_on_n,
    output logic            main_rail_en
);
    // released lines return to the pull-up level, never the last value
    assign line_n = ~pull;
    assign supply_on_n = ~suspend_ram_n;
    assign main_rail_en = suspend_ram_n;
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the power state sequencer
// Assumes: short debounce and pending counts of 4
// Notes:   lid strap tied low, so a low lid line means closed
`timescale 1ns/1ns
module tb_top;
    typedef struct {
        logic [4:0]                   req;
        acpi_power_pkg::power_state_t s;
    } row_t;
    logic                         sys_clk = 1'b0;
    logic                         rst_n = 1'b0;
    logic [7:0]                   pull = 8'h00;
    logic [7:0]                   line_n;
    acpi_power_pkg::os_request_t  os_req = '0;
    logic                         battery_event_clr = 1'b0;
    logic                         suspend_pending_n, suspend_ram_n, soft_off_n, standby_rail_en;
    logic                         low_power_hint, throttle, battery_event, module_reset_n;
    logic                         supply_on_n, main_rail_en;
    acpi_power_pkg::power_state_t power_state;
    int                           errors = 0;
    int                           comparisons = 0;
    row_t                         rows[7] = '{'{5'h11, acpi_power_pkg::ST_S1}, '{5'h09, acpi_power_pkg::ST_S3},
        '{5'h05, acpi_power_pkg::ST_S4}, '{5'h04, acpi_power_pkg::ST_S4},
        '{5'h03, acpi_power_pkg::ST_S5}, '{5'h02, acpi_power_pkg::ST_S5}, '{5'h1F, acpi_power_pkg::ST_S5}};

    always #5 sys_clk = ~sys_clk;

    acpi_power_state_control #(.DEBOUNCE(4), .PENDING(4)) dut (
        .sys_clk, .rst_n, .reset_button_n(line_n[0]), .battery_low_n(line_n[1]), .wake_n(line_n[2]),
        .sleep_button_n(line_n[3]), .lid_switch_n(line_n[4]), .thermal_alarm_n(line_n[5]),
        .power_button_n(line_n[6]), .thermal_trip_n(line_n[7]), .os_req, .lid_closed_level(1'b0),
        .battery_event_clr, .suspend_pending_n, .suspend_ram_n, .soft_off_n, .standby_rail_en,
        .low_power_hint, .throttle, .battery_event, .module_reset_n, .power_state
    );
    carrier_model partner (.suspend_ram_n, .pull, .line_n, .supply_on_n, .main_rail_en);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] expect_out(acpi_power_pkg::power_state_t s, logic ws);
        logic ram;
        logic off;
        ram = !(s inside {acpi_power_pkg::ST_S3, acpi_power_pkg::ST_S4, acpi_power_pkg::ST_S5});
        off = !(s inside {acpi_power_pkg::ST_S4, acpi_power_pkg::ST_S5});
        return {s, ram, off, off | ws, s == acpi_power_pkg::ST_S1, !ram};
    endfunction
    function automatic logic [7:0] snap();
        return {power_state, suspend_ram_n, soft_off_n, standby_rail_en, low_power_hint, supply_on_n};
    endfunction
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_state(acpi_power_pkg::power_state_t s);
        for (int i = 0; i < 60 && power_state !== s; i++) @(negedge sys_clk);
        chk("state", {5'h00, s}, {5'h00, power_state});
        if (power_state !== s) stop_test();
    endtask
    // button held past sync and debounce, then released and settled
    task automatic press(int idx);
        pull[idx] = 1'b1;
        repeat (10) @(negedge sys_clk);
        pull[idx] = 1'b0;
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic wake_up();
        press(acpi_power_pkg::IN_POWER_BTN);
        wait_state(acpi_power_pkg::ST_S0);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(negedge sys_clk);
        chk("reset outputs", expect_out(acpi_power_pkg::ST_S5, 1'b1), snap());
        chk("reset pending", 8'h01, {7'h00, suspend_pending_n});
        rst_n = 1'b1;
        wake_up();
        $display("test power-on done");
        foreach (rows[i]) begin
            os_req = acpi_power_pkg::os_request_t'(rows[i].req);
            @(negedge sys_clk);
            os_req = acpi_power_pkg::os_request_t'(rows[i].req & 5'h01);
            chk("pending", 8'h00, {7'h00, suspend_pending_n});
            wait_state(rows[i].s);
            chk("row outputs", expect_out(rows[i].s, rows[i].req[0]), snap());
            chk("main rail", {7'h00, suspend_ram_n}, {7'h00, main_rail_en});
            wake_up();
            chk("awake outputs", expect_out(acpi_power_pkg::ST_S0, 1'b1), snap());
        end
        $display("test request table done");
        os_req = acpi_power_pkg::os_request_t'(5'h01);
        press(acpi_power_pkg::IN_SLEEP_BTN);
        wait_state(acpi_power_pkg::ST_S3);
        press(acpi_power_pkg::IN_SLEEP_BTN);
        wait_state(acpi_power_pkg::ST_S0);
        $display("test sleep button done");
        press(acpi_power_pkg::IN_SLEEP_BTN);
        wait_state(acpi_power_pkg::ST_S3);
        press(acpi_power_pkg::IN_WAKE);
        wait_state(acpi_power_pkg::ST_S0);
        $display("test wake line done");
        pull[acpi_power_pkg::IN_LID] = 1'b1;
        wait_state(acpi_power_pkg::ST_S3);
        pull[acpi_power_pkg::IN_LID] = 1'b0;
        wait_state(acpi_power_pkg::ST_S0);
        $display("test lid done");
        os_req = acpi_power_pkg::os_request_t'(5'h02);
        @(negedge sys_clk);
        os_req = '0;
        wait_state(acpi_power_pkg::ST_S5);
        press(acpi_power_pkg::IN_WAKE);
        chk("ignored wake", expect_out(acpi_power_pkg::ST_S5, 1'b0), snap());
        wake_up();
        $display("test soft-off refusal done");
        pull[7] = 1'b1;
        wait_state(acpi_power_pkg::ST_S5);
        pull[7] = 1'b0;
        repeat (4) @(negedge sys_clk);
        wake_up();
        $display("test thermal trip done");
        press(acpi_power_pkg::IN_BATTERY_LOW);
        chk("battery set", 8'h01, {7'h00, battery_event});
        battery_event_clr = 1'b1;
        @(negedge sys_clk);
        battery_event_clr = 1'b0;
        @(negedge sys_clk);
        chk("battery clear", 8'h00, {7'h00, battery_event});
        $display("test battery done");
        pull[acpi_power_pkg::IN_THERM_ALARM] = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk("throttle on", 8'h01, {7'h00, throttle});
        pull[acpi_power_pkg::IN_THERM_ALARM] = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk("throttle off", 8'h00, {7'h00, throttle});
        $display("test thermal alarm done");
        pull[acpi_power_pkg::IN_RESET_BTN] = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk("module reset", 8'h00, {7'h00, module_reset_n});
        pull[acpi_power_pkg::IN_RESET_BTN] = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk("module release", 8'h01, {7'h00, module_reset_n});
        $display("test reset button done");
        stop_test();
    end
endmodule
